// *** src/dfs_params.svh ***
// Constants for the driver fault supervisor: timing, field positions, reset values
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DFS_CLK_MHZ       40
`define DFS_SC_LONG_US    100000
`define DFS_SC_SHORT_US   12500
`define DFS_OV_LONG_US    15000
`define DFS_OV_SHORT_US   3500
`define DFS_UV_US         1000
`define DFS_TIMER_W       23

// ----------------------------------------------------------------
// Serial word layout and reset values
// ----------------------------------------------------------------
`define DFS_WORD_BITS     16
`define DFS_NUM_OUTS      12
`define DFS_CTRL_RESET    16'he000
`define DFS_LAST_BIT      4'hf

`endif

// *** src/dfs_pkg.sv ***
// Types shared by the driver fault supervisor
package dfs_pkg;

	// Serial pins, sampled by the system clock
	typedef struct packed {
		logic csN;
		logic sclk;
		logic sdi;
	} dfs_serial_type;

	// Digital indications from the analog comparators
	typedef struct packed {
		logic        overVolt;
		logic        underVolt;
		logic        prewarnSet;
		logic        prewarnReset;
		logic        thermShutdown;
		logic        thermCool;
		logic [11:0] openLoad;
		logic [11:0] curLimit;
	} dfs_sense_type;

	// Input word written by the controller
	typedef struct packed {
		logic        run;
		logic        shortDelaySelect;
		logic        openLoadDetectN;
		logic [11:0] outCtrl;
		logic        statusResetRequest;
	} dfs_ctrl_type;

	// Status word returned to the controller
	typedef struct packed {
		logic        supplyFailFlag;
		logic        standby;
		logic        shortDetectedFlag;
		logic [11:0] outStatus;
		logic        tempPrewarnFlag;
	} dfs_status_type;

	// Serial link states, Gray along idle-shift-full-overrun
	typedef enum logic [1:0] {
		LINK_IDLE  = 2'b00,
		LINK_SHIFT = 2'b01,
		LINK_FULL  = 2'b11,
		LINK_OVER  = 2'b10
	} dfs_link_state_type;

endpackage

// *** src/dfs_fault_timer.sv ***
// Delay timer that expires after a fault has held for a programmed number of cycles
module dfs_fault_timer #(
	parameter int TW = 23
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          fault,
	input  wire logic [TW-1:0] limit,
	output logic               expired
);

	logic [TW-1:0] count_r;
	logic          atLimit;

	// Saturating count; any gap in the fault restarts it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (ce) begin
			if (!fault) begin
				count_r <= '0;
			end else if (!atLimit) begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	// Drops the same cycle the fault clears
	assign atLimit = (count_r >= limit);
	assign expired = fault & atLimit;

endmodule

// *** src/dfs_supervisor.sv ***
// Fault supervision, protection and serial word handling for a twelve-switch driver
//
// Operation
// (R1) Supply over/undervoltage starts timer; on expiry set supply-fail, disable all outputs.
// (R2) Outputs return at once when the supply is back in range.
// (R3) Supply-fail flag holds until a status-reset request is written.
// (R4) Open-load detect low enables pull-up on high side, pull-down on low side.
// (R5) Output status bit high on open load, low when load is connected.
// (R6) Switching an output on drops open-load detection for that output only.
// (R7) Prewarning flag set by set indication, cleared by lower reset indication.
// (R8) Chip select falling presents the prewarning flag on serial out at once.
// (R9) Chip select rising early abandons the transfer; both words stay unchanged.
// (R10) Thermal shutdown disables all outputs and forces every status bit high.
// (R11) Outputs return after thermal shutdown only when cool and status-reset written.
// (R12) Persistent current limit for the selected delay disables output, sets short flag.
// (R13) Current limit while prewarning is set disables that output at once.
// (R14) Status-reset request clears short flag and re-enables short-disabled outputs.
// (R15) Run bit low or disable pin low turns all outputs off; link still works.
// (R16) Outputs return when run bit is one and disable pin is high.
// (R17) Delay select picks 100/12.5 ms short delay and 15/3.5 ms overvoltage delay.
// (R18) Status bit 14 reads standby when run bit or disable pin is low.
// (R19) Input word resets with run, delay select, open-load detect high, rest low.
// (R20) Status word: prewarn bit 0, outputs 1-12, short 13, supply fail 15.
// (R21) Undervoltage delay is a fixed cycle count set as a build parameter.
// (R22) Every delay timer restarts when its fault clears before expiry.
`include "dfs_params.svh"

module dfs_supervisor #(
	parameter int TW          = `DFS_TIMER_W,
	parameter int SC_LONG_CYC = `DFS_SC_LONG_US * `DFS_CLK_MHZ,
	parameter int SC_SHRT_CYC = `DFS_SC_SHORT_US * `DFS_CLK_MHZ,
	parameter int OV_LONG_CYC = `DFS_OV_LONG_US * `DFS_CLK_MHZ,
	parameter int OV_SHRT_CYC = `DFS_OV_SHORT_US * `DFS_CLK_MHZ,
	parameter int UV_CYC      = `DFS_UV_US * `DFS_CLK_MHZ
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire dfs_pkg::dfs_serial_type serialIn,
	input  wire logic                  hwDisablePinN,
	input  wire dfs_pkg::dfs_sense_type  sense,
	output logic                       sdo,
	output logic                       sdoOe,
	output logic [5:0]                 highSideOutputs,
	output logic [5:0]                 lowSideOutputs,
	output logic [5:0]                 hsPullUpEn,
	output logic [5:0]                 lsPullDownEn,
	output logic                       tempPrewarnFlag,
	output logic                       shortDetectedFlag,
	output logic                       supplyFailFlag,
	output logic                       standby,
	output logic                       thermalOff
);

	localparam int NO = `DFS_NUM_OUTS;
	localparam int WB = `DFS_WORD_BITS;
	localparam int SW = $bits(dfs_pkg::dfs_sense_type) + $bits(dfs_pkg::dfs_serial_type) + 1;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0]           meta_r;
	logic [SW-1:0]           sync_r;
	dfs_pkg::dfs_sense_type  sSense;
	dfs_pkg::dfs_serial_type sSer;
	logic                    sInhN;

	// Every pin and comparator is asynchronous to clk
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= SW'(4'h8);                                        // Select parks high
			sync_r <= SW'(4'h8);
		end else if (ce) begin
			meta_r <= {sense, serialIn, hwDisablePinN};
			sync_r <= meta_r;
		end
	end

	assign {sSense, sSer, sInhN} = sync_r;

	// ----------------------------------------------------------------
	// Serial link edge detection
	// ----------------------------------------------------------------
	logic csPrev_r;
	logic sclkPrev_r;
	logic csFall;
	logic csRise;
	logic sclkRise;
	logic sclkFall;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			csPrev_r   <= 1'b1;                                     // Idle level, no false edge
			sclkPrev_r <= 1'b0;
		end else if (ce) begin
			csPrev_r   <= sSer.csN;
			sclkPrev_r <= sSer.sclk;
		end
	end

	// Clock edges count only inside a frame
	assign csFall   = csPrev_r & ~sSer.csN;
	assign csRise   = ~csPrev_r & sSer.csN;
	assign sclkRise = ~sclkPrev_r & sSer.sclk & ~sSer.csN;
	assign sclkFall = sclkPrev_r & ~sSer.sclk & ~sSer.csN;

	// ----------------------------------------------------------------
	// Serial link state and shift registers
	// ----------------------------------------------------------------
	dfs_pkg::dfs_link_state_type linkState_r;
	dfs_pkg::dfs_link_state_type linkState_nxt;
	logic [3:0]                  bitCnt_r;
	logic [WB-1:0]               shIn_r;
	logic [WB-1:0]               shOut_r;
	dfs_pkg::dfs_ctrl_type       ctrl_r;
	dfs_pkg::dfs_status_type     statusWord;
	logic                        wordTaken;
	logic                        srrPulse;

	// Word counting: exactly sixteen clocks make a valid frame
	always_comb begin
		linkState_nxt = linkState_r;
		case (linkState_r)
			dfs_pkg::LINK_IDLE: begin
				if (sclkRise) begin
					linkState_nxt = dfs_pkg::LINK_SHIFT;
				end
			end
			dfs_pkg::LINK_SHIFT: begin
				if (sclkRise && bitCnt_r == `DFS_LAST_BIT) begin
					linkState_nxt = dfs_pkg::LINK_FULL;
				end
			end
			dfs_pkg::LINK_FULL: begin
				if (sclkRise) begin
					linkState_nxt = dfs_pkg::LINK_OVER;
				end
			end
			dfs_pkg::LINK_OVER: begin
				linkState_nxt = dfs_pkg::LINK_OVER;
			end
			default: begin
				linkState_nxt = dfs_pkg::LINK_IDLE;
			end
		endcase
		if (csFall || sSer.csN) begin
			linkState_nxt = dfs_pkg::LINK_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			linkState_r <= dfs_pkg::LINK_IDLE;
			bitCnt_r    <= 4'h0;
		end else if (ce) begin
			linkState_r <= linkState_nxt;
			if (csFall) begin
				bitCnt_r <= 4'h0;
			end else if (sclkRise) begin
				bitCnt_r <= bitCnt_r + 4'h1;
			end
		end
	end

	// Input bits arrive LSB first on rising clock edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shIn_r <= '0;
		end else if (ce && sclkRise) begin
			shIn_r <= {sSer.sdi, shIn_r[WB-1:1]};
		end
	end

	// Status snapshot taken at frame start; bit 0 is the prewarning flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shOut_r <= '0;
		end else if (ce) begin
			if (csFall) begin
				shOut_r <= statusWord;                              // R8
			end else if (sclkFall) begin
				shOut_r <= {1'b0, shOut_r[WB-1:1]};
			end
		end
	end

	assign sdo   = shOut_r[0];                                          // R8
	assign sdoOe = ~sSer.csN;

	// Short frames leave the input word untouched
	assign wordTaken = csRise && (linkState_r == dfs_pkg::LINK_FULL);  // R9
	assign srrPulse  = wordTaken & shIn_r[0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= `DFS_CTRL_RESET;                                  // R19
		end else if (ce && wordTaken) begin
			ctrl_r <= shIn_r;                                           // R9
		end
	end

	// ----------------------------------------------------------------
	// Delay timers
	// ----------------------------------------------------------------
	logic [TW-1:0] ovLimit;
	logic [TW-1:0] scLimit;
	logic          ovExp;
	logic          uvExp;
	logic [NO-1:0] scOff_r;
	logic [NO-1:0] scFault;
	logic [NO-1:0] scExp;
	logic [NO-1:0] scSet;
	logic          tp_r;

	// One select bit steers both delays
	assign ovLimit = ctrl_r.shortDelaySelect ? TW'(OV_LONG_CYC) : TW'(OV_SHRT_CYC);   // R17
	assign scLimit = ctrl_r.shortDelaySelect ? TW'(SC_LONG_CYC) : TW'(SC_SHRT_CYC);   // R17

	dfs_fault_timer #(.TW(TW)) ovTimer (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.fault   (sSense.overVolt),                                 // R1
		.limit   (ovLimit),
		.expired (ovExp)
	);
	dfs_fault_timer #(.TW(TW)) uvTimer (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.fault   (sSense.underVolt),                                // R1
		.limit   (TW'(UV_CYC)),                                     // R21
		.expired (uvExp)
	);
	// A short that has been cut no longer counts
	assign scFault = sSense.curLimit & ~scOff_r;
	assign scSet   = scExp | (scFault & {NO{tp_r}});                   // R13
	genvar gi;
	generate
		for (gi = 0; gi < NO; gi++) begin : gScTimer
			dfs_fault_timer #(.TW(TW)) scTimer (
				.clk     (clk),
				.rst_n   (rst_n),
				.ce      (ce),
				.fault   (scFault[gi]),                             // R22
				.limit   (scLimit),
				.expired (scExp[gi])                                // R12
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Fault flags
	// ----------------------------------------------------------------
	logic psf_r;
	logic scd_r;
	logic thermOff_r;
	logic supplyOff;
	// Timer expiry drops as soon as the supply recovers
	assign supplyOff = ovExp | uvExp;                                   // R2
	// Set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			psf_r      <= 1'b0;
			scd_r      <= 1'b0;
			tp_r       <= 1'b0;
			thermOff_r <= 1'b0;
			scOff_r    <= '0;
		end else if (ce) begin
			if (supplyOff) begin
				psf_r <= 1'b1;                                      // R1
			end else if (srrPulse) begin
				psf_r <= 1'b0;                                      // R3
			end
			if (|scSet) begin
				scd_r <= 1'b1;                                      // R12
			end else if (srrPulse) begin
				scd_r <= 1'b0;                                      // R14
			end
			if (sSense.prewarnSet) begin
				tp_r <= 1'b1;                                       // R7
			end else if (sSense.prewarnReset) begin
				tp_r <= 1'b0;                                       // R7
			end
			if (sSense.thermShutdown) begin
				thermOff_r <= 1'b1;                                 // R10
			end else if (srrPulse && sSense.thermCool) begin
				thermOff_r <= 1'b0;                                 // R11
			end
			scOff_r <= (scOff_r & ~{NO{srrPulse}}) | scSet;            // R14
		end
	end

	// ----------------------------------------------------------------
	// Output stages and open-load test currents
	// ----------------------------------------------------------------
	logic          run;
	logic          allOn;
	logic [NO-1:0] drv_r;
	logic [NO-1:0] testEn_r;
	logic [NO-1:0] outStat;

	// Either inhibit path stops the stages; the link keeps running
	assign run   = ctrl_r.run & sInhN;                                  // R15 R16
	assign allOn = run & ~supplyOff & ~thermOff_r;                      // R1 R10
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			drv_r    <= '0;
			testEn_r <= '0;
		end else if (ce) begin
			drv_r    <= ctrl_r.outCtrl & ~scOff_r & ~scSet & {NO{allOn}};       // R12 R13
			testEn_r <= ~ctrl_r.outCtrl & {NO{~ctrl_r.openLoadDetectN}};    // R4 R6
		end
	end

	// On: shows drive; off with test current: shows open load
	assign outStat = drv_r | (testEn_r & sSense.openLoad);                // R5
	// Shutdown forces every status bit high
	assign statusWord = thermOff_r ? '1 :                                 // R10
		{psf_r, ~run, scd_r, outStat, tp_r};                            // R18 R20

	// Even index is a low side, odd index a high side
	generate
		for (gi = 0; gi < NO / 2; gi++) begin : gOutMap
			assign lowSideOutputs[gi]  = drv_r[2 * gi];
			assign highSideOutputs[gi] = drv_r[2 * gi + 1];
			assign lsPullDownEn[gi]    = testEn_r[2 * gi];
			assign hsPullUpEn[gi]      = testEn_r[2 * gi + 1];
		end
	endgenerate
	assign tempPrewarnFlag   = tp_r;
	assign shortDetectedFlag = scd_r;
	assign supplyFailFlag    = psf_r;
	assign standby           = ~run;
	assign thermalOff        = thermOff_r;

endmodule

// *** verif/dfs_supervisor_asserts.sv ***
// Concurrent checks on the fault supervisor's ports
module dfs_supervisor_asserts #(
	parameter int OV_SHRT_CYC = 10,
	parameter int UV_CYC      = 8
) (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic                    ce,
	input wire dfs_pkg::dfs_serial_type serialIn,
	input wire logic                    hwDisablePinN,
	input wire dfs_pkg::dfs_sense_type  sense,
	input wire logic                    sdo,
	input wire logic                    sdoOe,
	input wire logic [5:0]              highSideOutputs,
	input wire logic [5:0]              lowSideOutputs,
	input wire logic [5:0]              hsPullUpEn,
	input wire logic [5:0]              lsPullDownEn,
	input wire logic                    tempPrewarnFlag,
	input wire logic                    shortDetectedFlag,
	input wire logic                    supplyFailFlag,
	input wire logic                    standby,
	input wire logic                    thermalOff
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MinSup = (OV_SHRT_CYC < UV_CYC) ? OV_SHRT_CYC : UV_CYC;
	int supCnt_r;
	// Run length of a supply fault at the pins; any gap restarts it
	always_ff @(posedge clk) begin
		if (!rst_n || !(sense.overVolt || sense.underVolt))
			supCnt_r <= 0;
		else if (supCnt_r < MinSup)
			supCnt_r <= supCnt_r + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Protection paths; synchroniser lag is covered by the repetition counts
	therm_off_a: assert property (thermalOff && $past(thermalOff) |-> {highSideOutputs, lowSideOutputs} == 12'h000)
		else $error("outputs on in thermal shutdown");
	standby_off_a: assert property ($past(standby) |-> {highSideOutputs, lowSideOutputs} == 12'h000)
		else $error("outputs on in standby");
	supply_off_a: assert property ($rose(supplyFailFlag) |-> {highSideOutputs, lowSideOutputs} == 12'h000)
		else $error("outputs on at supply fail");
	supply_delay_a: assert property ($rose(supplyFailFlag) |-> supCnt_r >= MinSup)
		else $error("supply fail before delay");
	flags_hold_a: assert property ($fell(supplyFailFlag) || $fell(shortDetectedFlag) || $fell(thermalOff)
		|-> serialIn.csN && !$past(serialIn.csN, 8))
		else $error("flag cleared without a word");
	prewarn_sdo_a: assert property ($rose(sdoOe) |-> ##1 sdo == (tempPrewarnFlag | thermalOff))
		else $error("prewarn not on serial out");
	cs_idle_a: assert property (serialIn.csN [*5] |-> !sdoOe)
		else $error("serial out driven while idle");
	prewarn_set_a: assert property (sense.prewarnSet [*5] |-> tempPrewarnFlag)
		else $error("prewarn not set");
	prewarn_clr_a: assert property ((sense.prewarnReset && !sense.prewarnSet) [*5] |-> !tempPrewarnFlag)
		else $error("prewarn not cleared");
	test_current_a: assert property ((hsPullUpEn & highSideOutputs) == 6'h00
		&& (lsPullDownEn & lowSideOutputs) == 6'h00)
		else $error("test current on a driven output");
endmodule

bind dfs_supervisor dfs_supervisor_asserts #(.OV_SHRT_CYC(OV_SHRT_CYC), .UV_CYC(UV_CYC)) chk (
	.clk(clk), .rst_n(rst_n), .ce(ce), .serialIn(serialIn), .hwDisablePinN(hwDisablePinN),
	.sense(sense), .sdo(sdo), .sdoOe(sdoOe), .highSideOutputs(highSideOutputs),
	.lowSideOutputs(lowSideOutputs), .hsPullUpEn(hsPullUpEn), .lsPullDownEn(lsPullDownEn),
	.tempPrewarnFlag(tempPrewarnFlag), .shortDetectedFlag(shortDetectedFlag),
	.supplyFailFlag(supplyFailFlag), .standby(standby), .thermalOff(thermalOff)
);

// *** verif/dfs_mcu_model.sv ***
// Behavioural controller on the supervisor's serial pins
module dfs_mcu_model (
	input  wire logic              clk,
	input  wire logic              sdo,
	output dfs_pkg::dfs_serial_type ser
);
	timeunit 1ns;
	timeprecision 1ps;
	// Link clock parks low and select high between frames
	initial begin
		ser = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
	end
	// One frame, LSB first, 100 ns per link clock level; fewer than 16 clocks abandons it
	task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge clk);
		ser.csN = 1'b0;
		repeat (8) @(negedge clk);
		rd[0] = sdo;
		for (int i = 0; i < nbits; i++) begin
			ser.sdi = w[i];
			repeat (4) @(negedge clk);
			rd[i] = sdo;
			ser.sclk = 1'b1;
			repeat (4) @(negedge clk);
			ser.sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		ser.csN = 1'b1;
		ser.sdi = ~ser.sdi;
		repeat (8) @(negedge clk);
	endtask
endmodule

// *** verif/driver_fault_supervisor_tb.sv ***
// Self-checking bench for the driver fault supervisor
module driver_fault_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [15:0] w;
		logic [11:0] ol;
		logic [5:0]  hs;
		logic [5:0]  ls;
		logic [5:0]  pu;
		logic [5:0]  pd;
		logic [15:0] st;
	} dfs_row_type;
	logic                    clk;
	logic                    rst_n;
	logic                    ce;
	logic                    hwDisablePinN;
	dfs_pkg::dfs_sense_type  sense;
	dfs_pkg::dfs_serial_type ser;
	logic                    sdo;
	logic                    tpf;
	logic                    sdf;
	logic                    sff;
	logic                    standby;
	logic                    thermalOff;
	logic [5:0]              hs, ls, pu, pd;
	logic [15:0]             rd;
	int                      bad_count;
	int                      n_compared;
	dfs_row_type             rows [8];

	// Small delay counts keep the run short
	dfs_supervisor #(.SC_LONG_CYC(40), .SC_SHRT_CYC(20), .OV_LONG_CYC(30), .OV_SHRT_CYC(10), .UV_CYC(8)) uut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .serialIn(ser), .hwDisablePinN(hwDisablePinN), .sense(sense),
		.sdo(sdo), .sdoOe(), .highSideOutputs(hs), .lowSideOutputs(ls), .hsPullUpEn(pu), .lsPullDownEn(pd),
		.tempPrewarnFlag(tpf), .shortDetectedFlag(sdf), .supplyFailFlag(sff), .standby(standby),
		.thermalOff(thermalOff)
	);
	dfs_mcu_model mcu (.clk(clk), .sdo(sdo), .ser(ser));

	// Comparison and closing tasks
	task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_bit(input string name, input logic exp, input logic got);
		check_word(name, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic check_out(input logic [5:0] h, input logic [5:0] l);
		check_word("high side", {10'h000, h}, {10'h000, hs});
		check_word("low side", {10'h000, l}, {10'h000, ls});
	endtask
	task automatic wrap_up();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end
		else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog, well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		rows = '{
			'{16'he000, 12'h000, 6'h00, 6'h00, 6'h00, 6'h00, 16'h0000},
			'{16'he002, 12'h000, 6'h00, 6'h01, 6'h00, 6'h00, 16'h0002},
			'{16'he004, 12'h000, 6'h01, 6'h00, 6'h00, 6'h00, 16'h0004},
			'{16'hfffe, 12'h000, 6'h3f, 6'h3f, 6'h00, 6'h00, 16'h1ffe},
			'{16'h6ffe, 12'h000, 6'h00, 6'h00, 6'h00, 6'h00, 16'h4000},
			'{16'hc000, 12'h0a5, 6'h00, 6'h00, 6'h3f, 6'h3f, 16'h014a},
			'{16'hc806, 12'h000, 6'h01, 6'h21, 6'h3e, 6'h1e, 16'h0806},
			'{16'he004, 12'h000, 6'h01, 6'h00, 6'h00, 6'h00, 16'h0004}};
		bad_count = 0;
		n_compared = 0;
		ce = 1'b1;
		rst_n = 1'b0;
		hwDisablePinN = 1'b1;
		sense = '0;
		wait_n(10);
		rst_n = 1'b1;
		check_out(6'h00, 6'h00);
		wait_n(6);
		check_bit("standby", 1'b0, standby);
		check_word("pull-up", 16'h0000, {10'h000, pu});
		foreach (rows[i]) begin
			sense.openLoad = rows[i].ol;
			mcu.xfer(rows[i].w, 16, rd);
			check_out(rows[i].hs, rows[i].ls);
			check_word("pull-up", {10'h000, rows[i].pu}, {10'h000, pu});
			check_word("pull-down", {10'h000, rows[i].pd}, {10'h000, pd});
			mcu.xfer(rows[i].w, 16, rd);
			check_word("status", rows[i].st, rd);
		end
		// Short on HS1: long delay, then short delay with a gap that restarts the timer
		sense.curLimit = 12'h002;
		wait_n(30);
		check_out(6'h01, 6'h00);
		wait_n(20);
		check_out(6'h00, 6'h00);
		check_bit("short", 1'b1, sdf);
		sense.curLimit = 12'h000;
		mcu.xfer(16'ha005, 16, rd);
		check_bit("short", 1'b0, sdf);
		check_out(6'h01, 6'h00);
		sense.curLimit = 12'h002;
		wait_n(15);
		sense.curLimit = 12'h000;
		wait_n(3);
		sense.curLimit = 12'h002;
		wait_n(15);
		check_out(6'h01, 6'h00);
		wait_n(10);
		check_out(6'h00, 6'h00);
		// Prewarning cuts a short at once; abandoned frames leave both words alone
		sense.curLimit = 12'h000;
		sense.prewarnSet = 1'b1;
		mcu.xfer(16'he005, 16, rd);
		sense.prewarnSet = 1'b0;
		check_bit("prewarn", 1'b1, tpf);
		sense.curLimit = 12'h002;
		wait_n(5);
		check_out(6'h00, 6'h00);
		check_bit("short", 1'b1, sdf);
		sense.curLimit = 12'h000;
		mcu.xfer(16'h0000, 0, rd);
		check_bit("prewarn on sdo", 1'b1, rd[0]);
		mcu.xfer(16'h0001, 5, rd);
		check_bit("short", 1'b1, sdf);
		check_bit("standby", 1'b0, standby);
		sense.prewarnReset = 1'b1;
		wait_n(5);
		check_bit("prewarn", 1'b0, tpf);
		sense.prewarnReset = 1'b0;
		// Disable pin: outputs off, link still answers
		hwDisablePinN = 1'b0;
		mcu.xfer(16'he005, 16, rd);
		check_out(6'h00, 6'h00);
		mcu.xfer(16'he004, 16, rd);
		check_word("status", 16'h4000, rd);
		hwDisablePinN = 1'b1;
		wait_n(5);
		check_out(6'h01, 6'h00);
		// Supply faults: long overvoltage delay, then undervoltage
		sense.overVolt = 1'b1;
		wait_n(25);
		check_bit("supply", 1'b0, sff);
		wait_n(15);
		check_bit("supply", 1'b1, sff);
		check_out(6'h00, 6'h00);
		sense.overVolt = 1'b0;
		wait_n(5);
		check_out(6'h01, 6'h00);
		check_bit("supply", 1'b1, sff);
		mcu.xfer(16'he005, 16, rd);
		check_bit("supply", 1'b0, sff);
		sense.underVolt = 1'b1;
		wait_n(15);
		check_bit("supply", 1'b1, sff);
		sense.underVolt = 1'b0;
		// Thermal shutdown needs both cooling and a status reset
		sense.thermShutdown = 1'b1;
		wait_n(5);
		check_bit("thermal", 1'b1, thermalOff);
		check_out(6'h00, 6'h00);
		mcu.xfer(16'he004, 16, rd);
		check_word("status", 16'hffff, rd);
		sense.thermShutdown = 1'b0;
		mcu.xfer(16'he005, 16, rd);
		check_bit("thermal", 1'b1, thermalOff);
		sense.thermCool = 1'b1;
		mcu.xfer(16'he005, 16, rd);
		check_bit("thermal", 1'b0, thermalOff);
		check_out(6'h01, 6'h00);
		// Clock enable low freezes the supply timer; it counts again once enabled
		ce = 1'b0;
		sense.overVolt = 1'b1;
		wait_n(40);
		check_bit("supply", 1'b0, sff);
		ce = 1'b1;
		wait_n(40);
		check_bit("supply", 1'b1, sff);
		sense.overVolt = 1'b0;
		wrap_up();
	end
endmodule
